// [core/vpump_pkg.sv]
package vpump_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_SETPT = 8'h08;
	localparam logic [7:0] ADDR_PPTHR = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_VACUUM = 8'h18;
	// control register fields
	localparam int CTRL_IOLINK = 0;
	localparam int CTRL_PD_SUCTION = 1;
	localparam int CTRL_PD_DROPOFF = 2;
	localparam int CTRL_POL_IN = 3;
	localparam int CTRL_POL_PART_PRESENT_OUTPUT = 4;
	localparam int CTRL_POL_AUXILIARY_SIGNAL_OUTPUT = 5;
	localparam int CTRL_W = 6;
	// setpoint fields: value in [9:0], hysteresis in [25:16]
	localparam int VAL_LSB = 0;
	localparam int HYST_LSB = 16;
	localparam int VAC_W = 10;
	// values after reset, mbar
	localparam logic [9:0] SETPT_RST = 10'h258;
	localparam logic [9:0] HYST1_RST = 10'h014;
	localparam logic [9:0] THR_RST = 10'h1E0;
	localparam logic [9:0] HYST2_RST = 10'h014;
	localparam logic POL_PNP = 1'b0;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	// interrupt status bits
	localparam int IRQ_PP = 0;
	localparam int IRQ_DET = 1;
	localparam int IRQ_BLOW = 2;
	localparam int IRQ_W = 3;
	// timing
	localparam int CLK_KHZ = 32'h0003D090;
	localparam int T_IN_MS = 32'h00000003;
	localparam int T_OUT_MS = 32'h00000002;
	localparam int IN_FILT_CYC_DEF = T_IN_MS * CLK_KHZ;
	localparam int OUT_TICK_CYC_DEF = T_OUT_MS * CLK_KHZ;
	localparam int CNT_W = 20;
	typedef struct packed {
		logic suction;
		logic blowoff;
	} cmd_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SUCK = 3'b010,
		ST_BLOW = 3'b100
	} state_t;
endpackage

// [core/vacuum_pump_command_control.sv]
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Summary of operation
// R1: With suction and blowoff both asserted, blowoff runs and suction waits until blowoff drops.
// R2: In standard I/O mode the vent valve follows the blowoff input with no further qualification.
// R3: In IO-Link mode the master asks for blowoff with the drop-off bit and the device blows off while it is set.
// R4: In blowoff the vent valve stays open exactly as long as the blowoff command stands.
// R5: The part-detached flag sets when vacuum during suction rose above the part threshold and fell below it again.
// R6: The part-detached flag also reports that a picked-up workpiece has been deposited.
// R7: After reset the control setpoint is 600 mbar with a reset point 20 mbar lower, 580 mbar.
// R8: After reset the part-present threshold is 480 mbar with a reset point of 460 mbar.
// R9: After reset both inputs and both signal outputs use high-side polarity.
// R10: A change on a discrete command input takes effect within about 3 ms.
// R11: The signal output follows its condition within 2 ms typically and 3 ms at most.
// R12: The pump runs while suction is commanded without blowoff and stops when suction is withdrawn.
// R13: The part-present output sets above the threshold and clears below threshold minus hysteresis.
// R14: With no command the pump is off and the vent valve closed.
module vacuum_pump_command_control
	import vpump_pkg::*;
#(
	parameter int IN_FILT_CYC = IN_FILT_CYC_DEF,
	parameter int OUT_TICK_CYC = OUT_TICK_CYC_DEF
) (
	input wire logic clk, // 250 MHz clock
	input wire logic arst_n, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic suction_command_input, // discrete suction input
	input wire logic blowoff_command_input, // discrete blowoff input
	input wire logic [9:0] vacuum_mbar, // measured vacuum
	output logic pump_enable, // electric pump on
	output logic vent_valve, // vent valve open
	output logic part_present_output, // part present signal pin
	output logic auxiliary_signal_output, // pump running signal pin
	output logic part_detached_flag, // process data in, part detached
	output logic irq // level interrupt
);
	localparam logic [CNT_W-1:0] IN_LAST = CNT_W'(IN_FILT_CYC - 1);
	localparam logic [CNT_W-1:0] OUT_LAST = CNT_W'(OUT_TICK_CYC - 1);

	logic [CTRL_W-1:0] ctrl_ff;
	logic [9:0] setpt_ff, hyst1_ff, thr_ff, hyst2_ff;
	logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff, nxt_irq_stat, irq_ev;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff, irq_ff;
	logic [CNT_W-1:0] suc_cnt_ff, tick_cnt_ff;
	logic suc_filt_ff, blow_in_ff;
	state_t state_ff, nxt_state;
	logic pump_ff, vent_ff, pp_ff, nxt_pp, part_present_output_ff, auxiliary_signal_output_ff;
	logic seen_ff, det_ff, nxt_seen, nxt_det;

	// apb decode
	// unmapped offsets raise pslverr and read as zero
	wire setup = psel & ~penable;
	wire access = psel & penable & pready_ff;
	wire wr = access & pwrite;
	wire rd = access & ~pwrite;
	wire hit_ctrl = paddr == ADDR_CTRL;
	wire hit_stat = paddr == ADDR_STATUS;
	wire hit_setpt = paddr == ADDR_SETPT;
	wire hit_thr = paddr == ADDR_PPTHR;
	wire hit_istat = paddr == ADDR_IRQ_STAT;
	wire hit_imask = paddr == ADDR_IRQ_MASK;
	wire hit_vac = paddr == ADDR_VACUUM;
	wire mapped = hit_ctrl | hit_stat | hit_setpt | hit_thr | hit_istat | hit_imask | hit_vac;
	wire [31:0] stat_word = {24'h000000, 1'b0, state_ff, pump_ff, vent_ff, pp_ff, det_ff};
	wire [31:0] rd_word = hit_ctrl ? {26'h0000000, ctrl_ff} :
		hit_stat ? stat_word :
		hit_setpt ? {6'h00, hyst1_ff, 6'h00, setpt_ff} :
		hit_thr ? {6'h00, hyst2_ff, 6'h00, thr_ff} :
		hit_istat ? {29'h00000000, irq_stat_ff} :
		hit_imask ? {29'h00000000, irq_mask_ff} :
		hit_vac ? {22'h000000, vacuum_mbar} : 32'h00000000;

	// answer in the first access cycle; read data captured in setup
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup & ~mapped;
			prdata_ff <= setup ? rd_word : prdata_ff;
		end
	end

	// R7 R8 R9 factory defaults
	// setpoint stored only; the pump is not regulated to it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= CTRL_RST;
			setpt_ff <= SETPT_RST;
			hyst1_ff <= HYST1_RST;
			thr_ff <= THR_RST;
			hyst2_ff <= HYST2_RST;
			irq_mask_ff <= 3'h0;
		end else if (wr) begin
			if (hit_ctrl) ctrl_ff <= pwdata[CTRL_W-1:0];
			if (hit_setpt) setpt_ff <= pwdata[VAL_LSB +: VAC_W];
			if (hit_setpt) hyst1_ff <= pwdata[HYST_LSB +: VAC_W];
			if (hit_thr) thr_ff <= pwdata[VAL_LSB +: VAC_W];
			if (hit_thr) hyst2_ff <= pwdata[HYST_LSB +: VAC_W];
			if (hit_imask) irq_mask_ff <= pwdata[IRQ_W-1:0];
		end
	end

	// polarity: npn inverts the logic level
	wire iolink = ctrl_ff[CTRL_IOLINK];
	wire suc_lvl = suction_command_input ^ ctrl_ff[CTRL_POL_IN];
	wire blow_lvl = blowoff_command_input ^ ctrl_ff[CTRL_POL_IN];
	wire suc_diff = suc_lvl != suc_filt_ff;

	// R10 suction input filter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			suc_cnt_ff <= '0;
			suc_filt_ff <= 1'b0;
		end else begin
			suc_cnt_ff <= (suc_diff && suc_cnt_ff != IN_LAST) ? suc_cnt_ff + 1'b1 : '0;
			suc_filt_ff <= (suc_diff && suc_cnt_ff == IN_LAST) ? suc_lvl : suc_filt_ff;
		end
	end

	// R2 blowoff input only registered, never filtered
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) blow_in_ff <= 1'b0;
		else blow_in_ff <= blow_lvl;
	end

	// R3 command source by mode
	cmd_t cmd;
	assign cmd.suction = iolink ? ctrl_ff[CTRL_PD_SUCTION] : suc_filt_ff;
	assign cmd.blowoff = iolink ? ctrl_ff[CTRL_PD_DROPOFF] : blow_in_ff;

	// R1 blowoff wins over suction
	always_comb begin
		case ({cmd.blowoff, cmd.suction})
			2'b10, 2'b11: nxt_state = ST_BLOW;
			2'b01: nxt_state = ST_SUCK;
			2'b00: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// R4 R12 R14 pump and vent follow the state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_IDLE;
			pump_ff <= 1'b0;
			vent_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			pump_ff <= nxt_state == ST_SUCK;
			vent_ff <= nxt_state == ST_BLOW;
		end
	end

	// R13 part present with hysteresis, reset point saturates at zero
	wire [9:0] pp_rel = (thr_ff > hyst2_ff) ? thr_ff - hyst2_ff : 10'h000;
	wire above = vacuum_mbar > thr_ff;
	wire below = vacuum_mbar < thr_ff;
	assign nxt_pp = above | (pp_ff & ~(vacuum_mbar < pp_rel));

	// R5 R6 detached after pick-up then loss or deposit
	wire sucking = state_ff == ST_SUCK;
	wire suck_entry = (nxt_state == ST_SUCK) & ~sucking;
	wire det_set = seen_ff & ((sucking & below) | state_ff == ST_BLOW);
	assign nxt_seen = ~suck_entry & ~det_set & (seen_ff | (sucking & above));
	assign nxt_det = det_set | (det_ff & ~suck_entry);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pp_ff <= 1'b0;
			seen_ff <= 1'b0;
			det_ff <= 1'b0;
		end else begin
			pp_ff <= nxt_pp;
			seen_ff <= nxt_seen;
			det_ff <= nxt_det;
		end
	end

	// R11 output refresh every 2 ms, worst latency one tick period
	wire out_tick = tick_cnt_ff == OUT_LAST;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_cnt_ff <= '0;
			part_present_output_ff <= 1'b0;
			auxiliary_signal_output_ff <= 1'b0;
		end else begin
			tick_cnt_ff <= out_tick ? '0 : tick_cnt_ff + 1'b1;
			if (out_tick) part_present_output_ff <= pp_ff ^ ctrl_ff[CTRL_POL_PART_PRESENT_OUTPUT];
			if (out_tick) auxiliary_signal_output_ff <= pump_ff ^ ctrl_ff[CTRL_POL_AUXILIARY_SIGNAL_OUTPUT];
		end
	end

	// sticky events; a new event beats the read that clears it
	assign irq_ev[IRQ_PP] = nxt_pp & ~pp_ff;
	assign irq_ev[IRQ_DET] = det_set & ~det_ff;
	assign irq_ev[IRQ_BLOW] = (nxt_state == ST_BLOW) & (state_ff != ST_BLOW);
	assign nxt_irq_stat = irq_ev | (irq_stat_ff & ~{IRQ_W{rd & hit_istat}});
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_ff <= 3'h0;
			irq_ff <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq_ff <= |(nxt_irq_stat & irq_mask_ff);
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign pump_enable = pump_ff;
	assign vent_valve = vent_ff;
	assign part_present_output = part_present_output_ff;
	assign auxiliary_signal_output = auxiliary_signal_output_ff;
	assign part_detached_flag = det_ff;
	assign irq = irq_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence seq_picked;
		sucking && seen_ff;
	endsequence
	sequence seq_dropped;
		sucking && below;
	endsequence
	sequence seq_setup;
		psel && !penable;
	endsequence
	sequence seq_write;
		psel && penable && pwrite && pready;
	endsequence

	AST_BLOW_PRIO: assert property (cmd.blowoff && cmd.suction |=> vent_valve && !pump_enable) // R1
		else $error("suction ran during blowoff");
	AST_SIO_VENT: assert property (!iolink && blow_lvl ##1 !iolink |=> vent_valve) // R2
		else $error("vent did not follow blowoff input");
	AST_PD_DROP: assert property (iolink && ctrl_ff[CTRL_PD_DROPOFF] |=> vent_valve) // R3
		else $error("drop-off bit did not open vent");
	AST_VENT_OFF: assert property (!cmd.blowoff |=> !vent_valve) // R4
		else $error("vent open without blowoff command");
	AST_DET_LOSS: assert property (seq_picked ##0 seq_dropped |=> part_detached_flag) // R5
		else $error("part loss not flagged");
	AST_DET_DEPOSIT: assert property (seen_ff && state_ff == ST_BLOW |=> part_detached_flag) // R6
		else $error("deposit not flagged");
	AST_RST_SETPT: assert property ($rose(arst_n) |-> setpt_ff == 10'h258 && hyst1_ff == 10'h014) // R7
		else $error("control setpoint default wrong");
	AST_RST_THR: assert property ($rose(arst_n) |-> thr_ff == 10'h1E0 && pp_rel == 10'h1CC) // R8
		else $error("part threshold default wrong");
	AST_RST_POL: assert property ($rose(arst_n) |-> ctrl_ff[5:3] == 3'h0) // R9
		else $error("polarity default not high-side");
	AST_IN_FILT: assert property ($changed(suc_filt_ff) |-> $past(suc_cnt_ff) == IN_LAST) // R10
		else $error("suction input changed before filter time");
	AST_OUT_TICK: assert property ($changed(part_present_output) |-> $past(out_tick)) // R11
		else $error("signal output changed off tick");
	AST_PUMP_ON: assert property (cmd.suction && !cmd.blowoff |=> pump_enable ##0 !vent_valve) // R12
		else $error("pump not running under suction");
	AST_PP_HYST: assert property (pp_ff && vacuum_mbar >= pp_rel |=> pp_ff) // R13
		else $error("part present dropped inside hysteresis");
	AST_IDLE: assert property (!cmd.suction && !cmd.blowoff |=> !pump_enable && !vent_valve) // R14
		else $error("actuator active with no command");

	// bus handshake, zero wait states
	AST_APB_READY: assert property (seq_setup |=> pready)
		else $error("no ready in first access cycle");
	AST_APB_PULSE: assert property (pready |=> !pready)
		else $error("ready stood longer than one cycle");
	AST_APB_ERR: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	AST_APB_WR: assert property (seq_setup ##1 seq_write ##0 hit_setpt |=>
		setpt_ff == $past(pwdata[VAL_LSB +: VAC_W]))
		else $error("setpoint write did not land");

	// sticky interrupt status, set beats read-clear
	AST_IRQ_SET: assert property (|(irq_ev & irq_mask_ff) |=> irq)
		else $error("unmasked event raised no interrupt");
	AST_IRQ_HOLD: assert property (irq_stat_ff[IRQ_DET] && !(rd && hit_istat) |=>
		irq_stat_ff[IRQ_DET])
		else $error("status bit lost without a read");
	AST_IRQ_CLR: assert property (rd && hit_istat && irq_ev == 3'h0 |=> irq_stat_ff == 3'h0)
		else $error("status read did not clear");
	AST_IRQ_BLOW: assert property (irq_ev[IRQ_BLOW] |=> irq_stat_ff[IRQ_BLOW])
		else $error("blowoff entry not recorded");

	// actuators and part sensing
	AST_PUMP_OFF: assert property (!cmd.suction |=> !pump_enable) // R12
		else $error("pump ran without suction command");
	AST_PP_SET: assert property (vacuum_mbar > thr_ff |=> pp_ff) // R13
		else $error("part present not set above threshold");
	AST_PP_CLR: assert property (vacuum_mbar < pp_rel |=> !pp_ff) // R13
		else $error("part present held below reset point");
	AST_DET_CLEAR: assert property (suck_entry && !det_set |=> !part_detached_flag) // R5
		else $error("detached flag survived new suction");
endmodule

// [tb/cmd_driver.sv]
`timescale 1ns/1ps
module cmd_driver
	import vpump_pkg::*;
(
	input wire cmd_t req, // commands of the control unit
	input wire logic pol_npn, // 1 = low-side switching
	output logic suction_command_input, // suction pin
	output logic blowoff_command_input // blowoff pin
);
	assign suction_command_input = req.suction ^ pol_npn;
	assign blowoff_command_input = req.blowoff ^ pol_npn;
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
	import vpump_pkg::*;
	localparam int FILT = 8;
	localparam int TICK = 16;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd, rnd = 32'hE1E6286C;
	logic pready, pslverr, suction_command_input, blowoff_command_input;
	logic pump_enable, vent_valve, part_present_output, auxiliary_signal_output;
	logic part_detached_flag, irq;
	logic [9:0] vacuum_mbar = 10'h000;
	logic [1:0] cmd;
	logic npn = 1'b0;
	cmd_t req = '0;
	int n_errors = 0, checks = 0, cyc = 0;
	always #2 clk = ~clk;
	vacuum_pump_command_control #(.IN_FILT_CYC(FILT), .OUT_TICK_CYC(TICK))
		u_vacuum_pump_command_control (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .suction_command_input, .blowoff_command_input,
		.vacuum_mbar, .pump_enable, .vent_valve, .part_present_output,
		.auxiliary_signal_output, .part_detached_flag, .irq);
	cmd_driver u_cmd_driver (.req, .pol_npn(npn), .suction_command_input,
		.blowoff_command_input);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// pump wins only without blowoff; vent follows blowoff
	function automatic logic [1:0] exp_out(input logic s, input logic b);
		return {s & ~b, b};
	endfunction
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge clk);
	endtask
	// release happens at the pready edge, so a new setup needs one more edge
	// no wait-state limit here: the cycle ceiling ends a hung bus
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic done(input string name);
		$display("test %s done", name);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		apb(1'b0, ADDR_SETPT, 32'h00000000);
		`CHK(rd, 32'h00140258)
		apb(1'b0, ADDR_PPTHR, 32'h00000000);
		`CHK(rd, 32'h001401E0)
		apb(1'b0, ADDR_CTRL, 32'h00000000);
		`CHK(rd[5:3], 3'h0)
		apb(1'b0, 8'h3C, 32'h00000000);
		`CHK(err, 1'b1)
		done("defaults");
		vacuum_mbar <= 10'h1F4;
		cyc_wait(TICK + 4);
		`CHK(part_present_output, 1'b1)
		vacuum_mbar <= 10'h1D6;
		cyc_wait(TICK + 4);
		`CHK(part_present_output, 1'b1)
		vacuum_mbar <= 10'h1C2;
		cyc_wait(TICK + 4);
		`CHK(part_present_output, 1'b0)
		done("part_present");
		req.blowoff <= 1'b1;
		cyc_wait(4);
		`CHK({pump_enable, vent_valve}, 2'b01)
		req.suction <= 1'b1;
		cyc_wait(FILT + 4);
		`CHK({pump_enable, vent_valve}, 2'b01)
		req.blowoff <= 1'b0;
		cyc_wait(4);
		`CHK({pump_enable, vent_valve}, 2'b10)
		cyc_wait(TICK + 4);
		`CHK(auxiliary_signal_output, 1'b1)
		req.suction <= 1'b0;
		cyc_wait(FILT + 4);
		`CHK({pump_enable, vent_valve}, 2'b00)
		done("discrete");
		for (int i = 0; i < 12; i++) begin
			rnd = xs(rnd);
			cmd = (i < 4) ? i[1:0] : rnd[1:0];
			vacuum_mbar <= rnd[17:8];
			// drop-off bit is the blowoff request
			apb(1'b1, ADDR_CTRL, {29'h00000000, cmd, 1'b1});
			cyc_wait(3);
			`CHK({pump_enable, vent_valve}, exp_out(cmd[0], cmd[1]))
			apb(1'b0, ADDR_VACUUM, 32'h00000000);
			`CHK(rd, {22'h000000, rnd[17:8]})
		end
		done("iolink_random");
		apb(1'b1, ADDR_CTRL, 32'h00000001);
		vacuum_mbar <= 10'h000;
		apb(1'b1, ADDR_IRQ_MASK, 32'h00000002);
		apb(1'b0, ADDR_IRQ_STAT, 32'h00000000);
		cyc_wait(3);
		`CHK(irq, 1'b0)
		apb(1'b1, ADDR_CTRL, 32'h00000003);
		vacuum_mbar <= 10'h1F4;
		cyc_wait(3);
		`CHK(part_detached_flag, 1'b0)
		vacuum_mbar <= 10'h1D6;
		cyc_wait(3);
		`CHK(part_detached_flag, 1'b1)
		`CHK(irq, 1'b1)
		apb(1'b0, ADDR_IRQ_STAT, 32'h00000000);
		`CHK(rd[IRQ_DET], 1'b1)
		cyc_wait(3);
		`CHK(irq, 1'b0)
		apb(1'b1, ADDR_CTRL, 32'h00000001);
		vacuum_mbar <= 10'h1F4;
		apb(1'b1, ADDR_CTRL, 32'h00000003);
		cyc_wait(3);
		`CHK(part_detached_flag, 1'b0)
		apb(1'b1, ADDR_CTRL, 32'h00000007);
		cyc_wait(3);
		`CHK(part_detached_flag, 1'b1)
		done("detached");
		// low-side pins: driver and device invert together
		apb(1'b1, ADDR_CTRL, 32'h00000038);
		npn <= 1'b1;
		cyc_wait(TICK + 4);
		`CHK(part_present_output, 1'b0)
		`CHK(auxiliary_signal_output, 1'b1)
		req.blowoff <= 1'b1;
		cyc_wait(4);
		`CHK({pump_enable, vent_valve}, 2'b01)
		done("npn");
		apb(1'b1, ADDR_SETPT, 32'h000A0190);
		apb(1'b0, ADDR_SETPT, 32'h00000000);
		`CHK(rd, 32'h000A0190)
		req.blowoff <= 1'b0;
		npn <= 1'b0;
		arst_n <= 1'b0;
		cyc_wait(3);
		`CHK({pump_enable, vent_valve, part_detached_flag}, 3'h0)
		arst_n <= 1'b1;
		apb(1'b0, ADDR_SETPT, 32'h00000000);
		`CHK(rd, 32'h00140258)
		apb(1'b0, ADDR_CTRL, 32'h00000000);
		`CHK(rd[5:3], 3'h0)
		done("reset");
		finish_test();
	end
endmodule
